// [verilog/nfc_host.sv]
// Added by the designer: the register offsets and the strobed register port.
module nfc_host #(
	parameter int IO_W = 8
) (
	input  wire logic            sys_clk,
	input  wire logic            rst_n,
	input  wire logic [7:0]      bus_addr,
	input  wire logic [31:0]     bus_wdata,
	input  wire logic            bus_wr,
	input  wire logic            bus_rd,
	output logic [31:0]          bus_rdata,
	output logic                 ce_n,
	output logic                 cle,
	output logic                 ale,
	output logic                 we_n,
	output logic                 re_n,
	output logic                 wp_n,
	output logic [IO_W-1:0]      io_out,
	output logic                 io_oe,
	input  wire logic [IO_W-1:0] io_in,
	input  wire logic            ready_busy
);
	initial
	begin
		if (IO_W != 8 && IO_W != 16)
			$error("IO_W must be 8 or 16");
	end

	logic rst_s1, rst_sync_n;
	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			rst_s1     <= 1'b0;
			rst_sync_n <= 1'b0;
		end
		else
		begin
			rst_s1     <= 1'b1;
			rst_sync_n <= rst_s1;
		end
	end

	// only the low byte is ever used, upper byte of word parts is don't-care
	logic [7:0] io_s1, io_s2;
	logic       rb_s1, rb_s2;
	always_ff @(posedge sys_clk or negedge rst_sync_n)
	begin
		if (!rst_sync_n)
		begin
			io_s1 <= 8'h00;
			io_s2 <= 8'h00;
			rb_s1 <= 1'b0;
			rb_s2 <= 1'b0;
		end
		else
		begin
			io_s1 <= io_in[7:0];
			io_s2 <= io_s1;
			rb_s1 <= ready_busy;
			rb_s2 <= rb_s1;
		end
	end

	function automatic logic [7:0] first_cmd(input logic [2:0] op);
		unique case (op)
			nfc_pkg::OP_PROG, nfc_pkg::OP_CACHE: first_cmd = nfc_pkg::CMD_LOAD;
			nfc_pkg::OP_ERASE: first_cmd = nfc_pkg::CMD_ERASE1;
			nfc_pkg::OP_ID, nfc_pkg::OP_ONFI: first_cmd = nfc_pkg::CMD_ID;
			nfc_pkg::OP_STAT: first_cmd = nfc_pkg::CMD_STATUS;
			default: first_cmd = nfc_pkg::CMD_RESET;
		endcase
	endfunction

	function automatic logic [7:0] addr_byte(input logic [2:0] op,
		input logic [2:0] idx, input logic [11:0] col, input logic [15:0] row);
		if (op == nfc_pkg::OP_ID)
			addr_byte = nfc_pkg::ID_ADDR_STD;
		else if (op == nfc_pkg::OP_ONFI)
			addr_byte = nfc_pkg::ID_ADDR_ONFI;
		else if (op == nfc_pkg::OP_ERASE)
			addr_byte = idx[0] ? row[15:8] : row[7:0];
		else
			unique case (idx[1:0])
				2'h0: addr_byte = col[7:0];
				2'h1: addr_byte = {4'h0, col[11:8]};
				2'h2: addr_byte = row[7:0];
				default: addr_byte = row[15:8];
			endcase
	endfunction

	nfc_pkg::nfc_state_t state_reg, state_next;
	logic [2:0]  op_reg, op_next, idx_reg, idx_next;
	logic [11:0] dcnt_reg, dcnt_next;
	logic [7:0]  cnt_reg, cnt_next;
	logic        iss_reg, iss_next, ce_next;
	logic [7:0]  stat_reg, stat_next;
	logic [39:0] id_reg, id_next;
	logic [15:0] row_reg, row_next;
	logic [11:0] col_reg, col_next, len_reg, len_next;
	logic [7:0]  wd_reg, wd_next;
	logic        wfull_reg, wfull_next, wp_next, ref_reg, ref_next;
	logic [31:0] rdata_next;
	logic        eng_start, eng_idle, eng_done;
	nfc_pkg::nfc_kind_t eng_kind;
	logic [7:0]  eng_dout, eng_din, eng_io;
	logic        start_req, start_ok;
	logic [2:0]  n_addr, n_id;

	assign start_req = bus_wr && bus_addr == nfc_pkg::OFS_CTRL
		&& bus_wdata[2:0] != nfc_pkg::OP_NONE;
	// a reset may cut into a busy wait, nothing else may
	assign start_ok = start_req && (state_reg == nfc_pkg::S_IDLE
		|| (state_reg == nfc_pkg::S_WAIT
		&& bus_wdata[2:0] == nfc_pkg::OP_RESET));
	assign n_addr = (op_reg == nfc_pkg::OP_ERASE) ? nfc_pkg::ADDR_N_ERASE :
		(op_reg == nfc_pkg::OP_ID || op_reg == nfc_pkg::OP_ONFI) ?
		nfc_pkg::ADDR_N_ID : nfc_pkg::ADDR_N_PROG;
	assign n_id = (op_reg == nfc_pkg::OP_ONFI) ? nfc_pkg::ID_N_ONFI :
		nfc_pkg::ID_N_STD;

	always_comb
	begin
		state_next = state_reg;
		op_next    = op_reg;
		idx_next   = idx_reg;
		dcnt_next  = dcnt_reg;
		cnt_next   = cnt_reg;
		iss_next   = iss_reg;
		stat_next  = stat_reg;
		id_next    = id_reg;
		wfull_next = wfull_reg;
		eng_start  = 1'b0;
		eng_kind   = nfc_pkg::K_CMD;
		eng_dout   = 8'h00;
		if (eng_start)
			iss_next = 1'b1;
		unique case (state_reg)
			nfc_pkg::S_IDLE:
			begin
			end
			nfc_pkg::S_CMD1:
			begin
				eng_dout  = first_cmd(op_reg);
				// cache and program loads wait for the cache to be free
				eng_start = !iss_reg && (rb_s2
					|| op_reg == nfc_pkg::OP_RESET
					|| op_reg == nfc_pkg::OP_STAT);
			end
			nfc_pkg::S_ADDR:
			begin
				eng_kind  = nfc_pkg::K_ADDR;
				eng_dout  = addr_byte(op_reg, idx_reg, col_reg, row_reg);
				eng_start = !iss_reg;
			end
			nfc_pkg::S_DATA:
			begin
				eng_kind  = nfc_pkg::K_WR;
				eng_dout  = wd_reg;
				eng_start = !iss_reg && wfull_reg && dcnt_reg != 12'h000;
			end
			nfc_pkg::S_CMD2:
			begin
				eng_dout = (op_reg == nfc_pkg::OP_CACHE) ? nfc_pkg::CMD_CACHE :
					(op_reg == nfc_pkg::OP_ERASE) ? nfc_pkg::CMD_ERASE2 :
					nfc_pkg::CMD_CONFIRM;
				eng_start = !iss_reg;
			end
			nfc_pkg::S_WAIT:
			begin
				if (cnt_reg != 8'h00)
					cnt_next = cnt_reg - 8'h01;
				else if (rb_s2)
					state_next = nfc_pkg::S_STCMD;
			end
			nfc_pkg::S_STCMD:
			begin
				eng_dout  = nfc_pkg::CMD_STATUS;
				eng_start = !iss_reg;
			end
			nfc_pkg::S_STRD, nfc_pkg::S_IDRD:
			begin
				eng_kind = nfc_pkg::K_RD;
				if (cnt_reg != 8'h00)
					cnt_next = cnt_reg - 8'h01;
				else
					eng_start = !iss_reg;
			end
		endcase
		if (eng_start)
			iss_next = 1'b1;
		if (eng_start && state_reg == nfc_pkg::S_DATA)
			wfull_next = 1'b0;
		if (state_reg == nfc_pkg::S_DATA && dcnt_reg == 12'h000)
			state_next = nfc_pkg::S_CMD2;
		if (eng_done)
		begin
			iss_next = 1'b0;
			idx_next = idx_reg + 3'h1;
			unique case (state_reg)
				nfc_pkg::S_CMD1:
				begin
					idx_next = 3'h0;
					cnt_next = 8'(nfc_pkg::WHR_CYC);
					if (op_reg == nfc_pkg::OP_RESET)
					begin
						state_next = nfc_pkg::S_WAIT;
						cnt_next   = 8'(nfc_pkg::WB_CYC);
					end
					else if (op_reg == nfc_pkg::OP_STAT)
						state_next = nfc_pkg::S_STRD;
					else
						state_next = nfc_pkg::S_ADDR;
				end
				nfc_pkg::S_ADDR:
					if (idx_reg == n_addr - 3'h1)
					begin
						idx_next = 3'h0;
						cnt_next = 8'(nfc_pkg::WHR_CYC);
						state_next = (op_reg == nfc_pkg::OP_ERASE) ? nfc_pkg::S_CMD2
							: (op_reg == nfc_pkg::OP_ID
							|| op_reg == nfc_pkg::OP_ONFI) ? nfc_pkg::S_IDRD
							: nfc_pkg::S_DATA;
					end
				nfc_pkg::S_DATA:
					dcnt_next = dcnt_reg - 12'h001;
				nfc_pkg::S_CMD2:
				begin
					state_next = nfc_pkg::S_WAIT;
					cnt_next   = 8'(nfc_pkg::WB_CYC);
				end
				nfc_pkg::S_STCMD:
				begin
					state_next = nfc_pkg::S_STRD;
					cnt_next   = 8'(nfc_pkg::WHR_CYC);
				end
				nfc_pkg::S_STRD:
				begin
					stat_next  = eng_din;
					state_next = nfc_pkg::S_IDLE;
				end
				nfc_pkg::S_IDRD:
				begin
					id_next[idx_reg*8 +: 8] = eng_din;
					if (idx_reg == n_id - 3'h1)
						state_next = nfc_pkg::S_IDLE;
				end
				default:
				begin
				end
			endcase
		end
		if (start_ok)
		begin
			state_next = nfc_pkg::S_CMD1;
			op_next    = bus_wdata[2:0];
			idx_next   = 3'h0;
			dcnt_next  = len_reg;
			iss_next   = 1'b0;
		end
		if (bus_wr && bus_addr == nfc_pkg::OFS_WDATA)
			wfull_next = 1'b1;
		// own enable held through the status read, so polls stay per chip
		ce_next = (state_next == nfc_pkg::S_IDLE);
	end

	always_comb
	begin
		row_next = row_reg;
		col_next = col_reg;
		len_next = len_reg;
		wd_next  = wd_reg;
		wp_next  = wp_n;
		ref_next = ref_reg;
		if (bus_wr)
			unique case (bus_addr)
				nfc_pkg::OFS_CTRL:
				begin
					wp_next = bus_wdata[nfc_pkg::CTRL_WP_BIT];
					if (bus_wdata[nfc_pkg::CTRL_CLR_BIT])
						ref_next = 1'b0;
				end
				nfc_pkg::OFS_ROW: row_next = bus_wdata[15:0];
				nfc_pkg::OFS_COL: col_next = bus_wdata[11:0];
				nfc_pkg::OFS_LEN: len_next = bus_wdata[11:0];
				nfc_pkg::OFS_WDATA: wd_next = bus_wdata[7:0];
				default:
				begin
				end
			endcase
		// a refusal in the same cycle as its clear still shows
		if (start_req && !start_ok)
			ref_next = 1'b1;
		rdata_next = 32'h0000_0000;
		if (bus_rd)
			unique case (bus_addr)
				nfc_pkg::OFS_CTRL: rdata_next[nfc_pkg::CTRL_WP_BIT] = wp_n;
				nfc_pkg::OFS_ROW: rdata_next[15:0] = row_reg;
				nfc_pkg::OFS_COL: rdata_next[11:0] = col_reg;
				nfc_pkg::OFS_LEN: rdata_next[11:0] = len_reg;
				nfc_pkg::OFS_STATUS:
				begin
					rdata_next[nfc_pkg::ST_BUSY_BIT] =
						state_reg != nfc_pkg::S_IDLE;
					rdata_next[nfc_pkg::ST_WANT_BIT] =
						state_reg == nfc_pkg::S_DATA && !wfull_reg;
					rdata_next[nfc_pkg::ST_RB_BIT] = rb_s2;
					rdata_next[nfc_pkg::ST_REFUSED_BIT] = ref_reg;
					rdata_next[nfc_pkg::ST_BYTE_POS +: 8] = stat_reg;
				end
				nfc_pkg::OFS_ID_LO: rdata_next = id_reg[31:0];
				nfc_pkg::OFS_ID_HI: rdata_next[7:0] = id_reg[39:32];
				default:
				begin
				end
			endcase
	end

	always_ff @(posedge sys_clk or negedge rst_sync_n)
	begin
		if (!rst_sync_n)
		begin
			state_reg <= nfc_pkg::S_IDLE;
			op_reg    <= nfc_pkg::OP_NONE;
			idx_reg   <= 3'h0;
			dcnt_reg  <= 12'h000;
			cnt_reg   <= 8'h00;
			iss_reg   <= 1'b0;
			stat_reg  <= nfc_pkg::STAT_RESET_VAL;
			id_reg    <= 40'h00_0000_0000;
			row_reg   <= 16'h0000;
			col_reg   <= 12'h000;
			len_reg   <= 12'h000;
			wd_reg    <= 8'h00;
			wfull_reg <= 1'b0;
			wp_n      <= 1'b0;
			ref_reg   <= 1'b0;
			ce_n      <= 1'b1;
			bus_rdata <= 32'h0000_0000;
		end
		else
		begin
			state_reg <= state_next;
			op_reg    <= op_next;
			idx_reg   <= idx_next;
			dcnt_reg  <= dcnt_next;
			cnt_reg   <= cnt_next;
			iss_reg   <= iss_next;
			stat_reg  <= stat_next;
			id_reg    <= id_next;
			row_reg   <= row_next;
			col_reg   <= col_next;
			len_reg   <= len_next;
			wd_reg    <= wd_next;
			wfull_reg <= wfull_next;
			wp_n      <= wp_next;
			ref_reg   <= ref_next;
			ce_n      <= ce_next;
			bus_rdata <= rdata_next;
		end
	end

	nfc_cycle i_nfc_cycle (
		.sys_clk  (sys_clk),
		.rst_n    (rst_sync_n),
		.start    (eng_start),
		.kind     (eng_kind),
		.dout     (eng_dout),
		.din_sync (io_s2),
		.idle     (eng_idle),
		.done     (eng_done),
		.din      (eng_din),
		.cle      (cle),
		.ale      (ale),
		.we_n     (we_n),
		.re_n     (re_n),
		.io_out   (eng_io),
		.io_oe    (io_oe)
	);
	assign io_out = IO_W'(eng_io);

	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!rst_sync_n);

	property p_load_ready;
		eng_start && eng_kind == nfc_pkg::K_CMD
			&& eng_dout == nfc_pkg::CMD_LOAD |-> rb_s2;
	endproperty
	a_load_ready: assert property (p_load_ready) else $error("load while busy");
	property p_busy_cmds;
		eng_start && eng_kind == nfc_pkg::K_CMD && !rb_s2 |->
			eng_dout == nfc_pkg::CMD_STATUS || eng_dout == nfc_pkg::CMD_RESET
			|| state_reg == nfc_pkg::S_CMD2;
	endproperty
	a_busy_cmds: assert property (p_busy_cmds) else $error("bad busy cmd");
	property p_cache_code;
		eng_start && eng_dout == nfc_pkg::CMD_CACHE
			&& eng_kind == nfc_pkg::K_CMD |-> op_reg == nfc_pkg::OP_CACHE;
	endproperty
	a_cache_code: assert property (p_cache_code) else $error("stray 15h");
	property p_id_addr;
		eng_start && eng_kind == nfc_pkg::K_ADDR && op_reg == nfc_pkg::OP_ID
			|-> eng_dout == nfc_pkg::ID_ADDR_STD;
	endproperty
	a_id_addr: assert property (p_id_addr) else $error("bad id address");
	property p_confirm_wait;
		eng_done && state_reg == nfc_pkg::S_CMD2 |=> state_reg == nfc_pkg::S_WAIT
			[*2];
	endproperty
	a_confirm_wait: assert property (p_confirm_wait) else $error("no wait");
	property p_read_hiz;
		state_reg == nfc_pkg::S_STRD && !eng_idle |-> ##1 !io_oe;
	endproperty
	a_read_hiz: assert property (p_read_hiz) else $error("drive on read");
	property p_stat_store;
		eng_done && state_reg == nfc_pkg::S_STRD |=> stat_reg == $past(eng_din)
			&& state_reg == nfc_pkg::S_IDLE;
	endproperty
	a_stat_store: assert property (p_stat_store) else $error("status lost");
	property p_wait_ready;
		state_reg == nfc_pkg::S_WAIT && state_next == nfc_pkg::S_STCMD
			|-> rb_s2 && cnt_reg == 8'h00;
	endproperty
	a_wait_ready: assert property (p_wait_ready) else $error("early poll");
	property p_onfi_len;
		state_reg == nfc_pkg::S_IDRD && op_reg == nfc_pkg::OP_ONFI
			|-> idx_reg < nfc_pkg::ID_N_ONFI;
	endproperty
	a_onfi_len: assert property (p_onfi_len) else $error("onfi overrun");
	c_cache: cover property (eng_start && eng_dout == nfc_pkg::CMD_CACHE
		&& eng_kind == nfc_pkg::K_CMD);
	c_erase: cover property (eng_start && eng_dout == nfc_pkg::CMD_ERASE2
		&& eng_kind == nfc_pkg::K_CMD);
	c_id: cover property (state_reg == nfc_pkg::S_IDRD
		##1 state_reg == nfc_pkg::S_IDLE);
endmodule

// [verilog/nfc_pkg.sv]
package nfc_pkg;
	localparam int CLK_MHZ    = 100;
	localparam int T_PHASE_NS = 20;
	localparam int PHASE_CYC  = (T_PHASE_NS * CLK_MHZ + 999) / 1000;
	localparam int T_WB_NS    = 100;
	localparam int WB_CYC     = (T_WB_NS * CLK_MHZ + 999) / 1000;
	localparam int T_WHR_NS   = 80;
	localparam int WHR_CYC    = (T_WHR_NS * CLK_MHZ + 999) / 1000;

	localparam logic [7:0] OFS_CTRL   = 8'h00;
	localparam logic [7:0] OFS_ROW    = 8'h04;
	localparam logic [7:0] OFS_COL    = 8'h08;
	localparam logic [7:0] OFS_LEN    = 8'h0C;
	localparam logic [7:0] OFS_WDATA  = 8'h10;
	localparam logic [7:0] OFS_STATUS = 8'h14;
	localparam logic [7:0] OFS_ID_LO  = 8'h18;
	localparam logic [7:0] OFS_ID_HI  = 8'h1C;

	localparam int CTRL_WP_BIT    = 8;
	localparam int CTRL_CLR_BIT   = 31;
	localparam int ST_BUSY_BIT    = 0;
	localparam int ST_WANT_BIT    = 1;
	localparam int ST_RB_BIT      = 2;
	localparam int ST_REFUSED_BIT = 3;
	localparam int ST_BYTE_POS    = 8;
	localparam logic [7:0] STAT_RESET_VAL = 8'hFF;

	localparam logic [7:0] CMD_LOAD    = 8'h80;
	localparam logic [7:0] CMD_CONFIRM = 8'h10;
	localparam logic [7:0] CMD_CACHE   = 8'h15;
	localparam logic [7:0] CMD_ERASE1  = 8'h60;
	localparam logic [7:0] CMD_ERASE2  = 8'hD0;
	localparam logic [7:0] CMD_ID      = 8'h90;
	localparam logic [7:0] CMD_STATUS  = 8'h70;
	localparam logic [7:0] CMD_RESET   = 8'hFF;
	localparam logic [7:0] ID_ADDR_STD  = 8'h00;
	localparam logic [7:0] ID_ADDR_ONFI = 8'h20;

	localparam logic [2:0] OP_NONE  = 3'h0;
	localparam logic [2:0] OP_PROG  = 3'h1;
	localparam logic [2:0] OP_CACHE = 3'h2;
	localparam logic [2:0] OP_ERASE = 3'h3;
	localparam logic [2:0] OP_ID    = 3'h4;
	localparam logic [2:0] OP_ONFI  = 3'h5;
	localparam logic [2:0] OP_STAT  = 3'h6;
	localparam logic [2:0] OP_RESET = 3'h7;

	localparam logic [2:0] ADDR_N_PROG  = 3'h4;
	localparam logic [2:0] ADDR_N_ERASE = 3'h2;
	localparam logic [2:0] ADDR_N_ID    = 3'h1;
	localparam logic [2:0] ID_N_STD     = 3'h5;
	localparam logic [2:0] ID_N_ONFI    = 3'h4;

	typedef enum logic [1:0] {
		K_CMD  = 2'h0,
		K_ADDR = 2'h1,
		K_WR   = 2'h2,
		K_RD   = 2'h3
	} nfc_kind_t;

	typedef enum logic [3:0] {
		S_IDLE  = 4'h0,
		S_CMD1  = 4'h1,
		S_ADDR  = 4'h3,
		S_DATA  = 4'h2,
		S_CMD2  = 4'h6,
		S_WAIT  = 4'h7,
		S_STCMD = 4'h5,
		S_STRD  = 4'h4,
		S_IDRD  = 4'hC
	} nfc_state_t;
endpackage

// [verilog/nfc_cycle.sv]
module nfc_cycle #(
	parameter int PHASE = nfc_pkg::PHASE_CYC
) (
	input  wire logic               sys_clk,
	input  wire logic               rst_n,
	input  wire logic               start,
	input  wire nfc_pkg::nfc_kind_t kind,
	input  wire logic [7:0]         dout,
	input  wire logic [7:0]         din_sync,
	output logic                    idle,
	output logic                    done,
	output logic [7:0]              din,
	output logic                    cle,
	output logic                    ale,
	output logic                    we_n,
	output logic                    re_n,
	output logic [7:0]              io_out,
	output logic                    io_oe
);
	initial
	begin
		if (PHASE < 2 || PHASE > 255)
			$error("PHASE must lie in 2..255");
	end

	logic [7:0] div_reg, div_next;
	logic [1:0] ph_reg, ph_next;
	logic       act_reg, act_next;
	logic       done_next, cle_next, ale_next, we_next, re_next, oe_next;
	logic [7:0] din_next, out_next;
	nfc_pkg::nfc_kind_t kind_reg, kind_next;
	logic       tick;

	assign tick = act_reg && (div_reg == 8'(PHASE - 1));
	assign idle = !act_reg;

	always_comb
	begin
		div_next  = div_reg;
		ph_next   = ph_reg;
		act_next  = act_reg;
		kind_next = kind_reg;
		done_next = 1'b0;
		cle_next  = cle;
		ale_next  = ale;
		we_next   = we_n;
		re_next   = re_n;
		oe_next   = io_oe;
		out_next  = io_out;
		din_next  = din;
		if (!act_reg)
		begin
			if (start)
			begin
				act_next  = 1'b1;
				div_next  = 8'h00;
				ph_next   = 2'h0;
				kind_next = kind;
				cle_next  = (kind == nfc_pkg::K_CMD);
				ale_next  = (kind == nfc_pkg::K_ADDR);
				oe_next   = (kind != nfc_pkg::K_RD);
				out_next  = dout;
			end
		end
		else
		begin
			div_next = tick ? 8'h00 : div_reg + 8'h01;
			if (tick)
			begin
				ph_next = ph_reg + 2'h1;
				unique case (ph_reg)
					2'h0:
					begin
						we_next = (kind_reg == nfc_pkg::K_RD);
						re_next = (kind_reg != nfc_pkg::K_RD);
					end
					2'h1:
					begin
					end
					2'h2:
					begin
						// sampled late so the two-stage sync has settled
						if (kind_reg == nfc_pkg::K_RD)
							din_next = din_sync;
						we_next = 1'b1;
						re_next = 1'b1;
					end
					2'h3:
					begin
						act_next  = 1'b0;
						done_next = 1'b1;
						cle_next  = 1'b0;
						ale_next  = 1'b0;
						oe_next   = 1'b0;
					end
				endcase
			end
		end
	end

	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			div_reg  <= 8'h00;
			ph_reg   <= 2'h0;
			act_reg  <= 1'b0;
			kind_reg <= nfc_pkg::K_CMD;
			done     <= 1'b0;
			cle      <= 1'b0;
			ale      <= 1'b0;
			we_n     <= 1'b1;
			re_n     <= 1'b1;
			io_oe    <= 1'b0;
			io_out   <= 8'h00;
			din      <= 8'h00;
		end
		else
		begin
			div_reg  <= div_next;
			ph_reg   <= ph_next;
			act_reg  <= act_next;
			kind_reg <= kind_next;
			done     <= done_next;
			cle      <= cle_next;
			ale      <= ale_next;
			we_n     <= we_next;
			re_n     <= re_next;
			io_oe    <= oe_next;
			io_out   <= out_next;
			din      <= din_next;
		end
	end
endmodule

// [bench/nfc_dev_model.sv]
module nfc_dev_model #(
	parameter logic [7:0] MFR_CODE = 8'h5A, // arbitrary value
	parameter logic [7:0] DEV_CODE = 8'h3C, // arbitrary value
	parameter int         CACHE_T  = 40,
	parameter int         ARR_T    = 300
) (
	input  wire logic       sys_clk,
	input  wire logic       ce_n,
	input  wire logic       cle,
	input  wire logic       ale,
	input  wire logic       we_n,
	input  wire logic       re_n,
	input  wire logic       wp_n,
	input  wire logic [7:0] io,
	input  wire logic       fail_in,
	output logic [7:0]      io_in,
	output logic            ready_busy
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [7:0]  idb [0:4];
	logic [7:0]  oval = 8'h00;
	logic [7:0]  dsum = 8'h00;
	logic [15:0] abuf, last_row;
	int          cc = 0, ac = 0, idx = 0;
	logic        ld = 0, st_mode = 0, id_wait = 0;
	logic        pend = 0, sr0 = 0, sr1 = 0;
	wire  [7:0]  sb = {wp_n, cc == 0, ac == 0, 3'h0, sr1, sr0};
	assign ready_busy = (cc == 0);
	// released bus shows the inverse, never a stale match
	assign io_in = (!ce_n && !re_n) ? oval : ~oval;
	always @(posedge we_n)
		if (!ce_n && cle && (cc == 0 || io == 8'h70 || io == 8'hFF))
		begin
			st_mode = (io == 8'h70);
			id_wait = (io == 8'h90);
			case (io)
				8'h80:
				begin
					ld = 1;
					dsum = 8'h00;
				end
				8'h10, 8'h15, 8'hD0:
				begin
					if (ac != 0)
						sr0 = pend;
					pend = fail_in;
					ld = 0;
					last_row = abuf;
					ac = ARR_T;
					cc = (io == 8'h15) ? CACHE_T : ARR_T;
				end
				8'hFF:
				begin
					{sr0, sr1, pend, ld} = 4'h0;
					ac = 5;
					cc = 5;
				end
				default: ;
			endcase
		end
		else if (!ce_n && ale)
		begin
			abuf = {io, abuf[15:8]};
			idx = 0;
			if (id_wait && io == 8'h20)
				idb = '{8'h4F, 8'h4E, 8'h46, 8'h49, 8'h00};
			else if (id_wait)
				idb = '{MFR_CODE, DEV_CODE, 8'h80, 8'h15, 8'h02};
		end
		else if (!ce_n && ld)
			dsum = dsum + io;
	always @(negedge re_n)
		oval = st_mode ? sb : idb[idx];
	always @(posedge re_n)
		idx++;
	always @(posedge sys_clk)
	begin
		if (cc == 1)
			sr1 = sr0;
		if (ac == 1)
		begin
			sr1 = sr0;
			sr0 = pend;
		end
		if (cc != 0)
			cc--;
		if (ac != 0)
			ac--;
	end
endmodule

// [bench/tb_nfc_host.sv]
module tb_nfc_host;
	timeunit 1ns;
	timeprecision 1ps;
	localparam logic [7:0] MFR = 8'h5A; // arbitrary value
	localparam logic [7:0] DEV = 8'h3C; // arbitrary value
	localparam logic [7:0] A_CT = nfc_pkg::OFS_CTRL;
	localparam logic [7:0] A_ST = nfc_pkg::OFS_STATUS;
	typedef struct {
		string       nm;
		logic [31:0] m;
		logic [31:0] e;
	} nfc_note_t;
	logic        sys_clk = 0, rst_n = 0, bus_wr = 0, bus_rd = 0;
	logic        want = 0, chk_q = 0, wp = 0, fail = 0;
	logic [7:0]  bus_addr = 8'h00, sum, io_out, io_in;
	logic [31:0] bus_wdata = 32'h0, bus_rdata, st;
	logic        ce_n, cle, ale, we_n, re_n, wp_n, io_oe, ready_busy;
	int          n_errors = 0, n_compared = 0;
	nfc_note_t   q[$], nt;
	always #5 sys_clk = ~sys_clk;
	nfc_host i_nfc_host (.sys_clk(sys_clk), .rst_n(rst_n),
		.bus_addr(bus_addr), .bus_wdata(bus_wdata), .bus_wr(bus_wr),
		.bus_rd(bus_rd), .bus_rdata(bus_rdata), .ce_n(ce_n), .cle(cle),
		.ale(ale), .we_n(we_n), .re_n(re_n), .wp_n(wp_n), .io_out(io_out),
		.io_oe(io_oe), .io_in(io_in), .ready_busy(ready_busy));
	nfc_dev_model #(.MFR_CODE(MFR), .DEV_CODE(DEV)) i_nfc_dev_model (
		.sys_clk(sys_clk), .ce_n(ce_n), .cle(cle), .ale(ale), .we_n(we_n),
		.re_n(re_n), .wp_n(wp_n), .io(io_out), .fail_in(fail),
		.io_in(io_in), .ready_busy(ready_busy));
	task check(string nm, logic [31:0] seen, logic [31:0] exp);
		n_compared++;
		if (seen !== exp)
		begin
			n_errors++;
			$display("FAIL %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task complete_run;
		$display("compared %0d mismatches %0d", n_compared, n_errors);
		if (n_errors == 0 && n_compared > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	always @(posedge sys_clk)
	begin
		if (chk_q)
		begin
			nt = q.pop_front();
			check(nt.nm, bus_rdata & nt.m, nt.e);
		end
		chk_q <= bus_rd & want;
	end
	task wr(logic [7:0] a, logic [31:0] d);
		@(posedge sys_clk);
		bus_addr <= a;
		bus_wdata <= d;
		bus_wr <= 1'b1;
		@(posedge sys_clk);
		bus_wr <= 1'b0;
	endtask
	task rd(logic [7:0] a, string nm, logic [31:0] m, e, logic w);
		@(posedge sys_clk);
		bus_addr <= a;
		bus_rd <= 1'b1;
		want <= w;
		if (w)
			q.push_back('{nm, m, e});
		@(posedge sys_clk);
		bus_rd <= 1'b0;
		#1 st = bus_rdata;
	endtask
	task poll(int b, logic v);
		int k;
		k = 0;
		do
		begin
			rd(A_ST, "", 32'h0, 32'h0, 1'b0);
			k++;
		end
		while (st[b] !== v && k < 2000);
		if (k >= 2000)
			check("poll", 32'h0, 32'h1);
	endtask
	task op(logic [2:0] o);
		wr(A_CT, {23'h0, wp, 5'h0, o});
		poll(nfc_pkg::ST_BUSY_BIT, 1'b0);
	endtask
	task sbyte(string nm, logic [7:0] e, logic rf);
		rd(A_ST, nm, 32'h0000FF0D, {16'h0, e, 4'h0, rf, 3'h4}, 1'b1);
	endtask
	task prog(logic [2:0] o, logic f, logic [15:0] r);
		sum = 8'h00;
		fail <= f;
		wr(nfc_pkg::OFS_ROW, {16'h0, r});
		rd(nfc_pkg::OFS_ROW, "row reg", 32'hFFFFFFFF,
			{16'h0, r}, 1'b1);
		wr(nfc_pkg::OFS_LEN, 32'h4);
		wr(A_CT, {23'h0, wp, 5'h0, o});
		repeat (4)
		begin
			poll(nfc_pkg::ST_WANT_BIT, 1'b1);
			st = {24'h0, 8'($urandom)};
			sum = sum + st[7:0];
			wr(nfc_pkg::OFS_WDATA, st);
		end
		poll(nfc_pkg::ST_BUSY_BIT, 1'b0);
		check("page sum", i_nfc_dev_model.dsum, sum);
		check("page row", i_nfc_dev_model.last_row, r);
	endtask
	initial
	begin
		void'($urandom(32'h00dbda3b));
		repeat (3) @(posedge sys_clk);
		rst_n <= 1'b1;
		repeat (3) @(posedge sys_clk);
		sbyte("reset status", 8'hFF, 1'b0);
		rd(8'h40, "unmapped", 32'hFFFFFFFF, 32'h0, 1'b1);
		st = $urandom;
		wr(nfc_pkg::OFS_COL, st);
		rd(nfc_pkg::OFS_COL, "col reg", 32'hFFFFFFFF,
			{20'h0, st[11:0]}, 1'b1);
		check("wp pin", wp_n, 1'b0);
		$display("test reset done");
		repeat (4)
		begin
			wp = 1'($urandom);
			op(3'h6);
			sbyte("status op", {wp, 7'h60}, 1'b0);
		end
		rd(A_CT, "wp bit", 32'hFFFFFFFF, {23'h0, wp, 8'h00}, 1'b1);
		$display("test status done");
		wp = 1'b1;
		op(3'h4);
		rd(nfc_pkg::OFS_ID_LO, "id 0-3", 32'hFFFFFFFF,
			{8'h15, 8'h80, DEV, MFR}, 1'b1);
		rd(nfc_pkg::OFS_ID_HI, "id 4", 32'hFF, 32'h02, 1'b1);
		op(3'h5);
		rd(nfc_pkg::OFS_ID_LO, "sig", 32'hFFFFFFFF, 32'h49464E4F, 1'b1);
		$display("test id done");
		prog(3'h1, 1'b0, 16'($urandom));
		sbyte("program", 8'hE0, 1'b0);
		prog(3'h2, 1'b1, 16'h0040);
		sbyte("cache 1", 8'hC0, 1'b0);
		prog(3'h2, 1'b0, 16'h0041);
		sbyte("cache 2", 8'hC3, 1'b0);
		for (int k = 0; k < 50 && !st[13]; k++)
			op(3'h6);
		sbyte("cache end", 8'hE2, 1'b0);
		$display("test program done");
		fail <= 1'b1;
		wr(nfc_pkg::OFS_ROW, 32'h1FC0);
		wr(A_CT, {23'h0, wp, 8'h03});
		wr(A_CT, {23'h0, wp, 8'h04});
		poll(nfc_pkg::ST_BUSY_BIT, 1'b0);
		sbyte("erase", 8'hE1, 1'b1);
		check("erase row", i_nfc_dev_model.last_row, 16'h1FC0);
		wr(A_CT, {1'b1, 22'h0, wp, 8'h00});
		sbyte("refused clear", 8'hE1, 1'b0);
		$display("test erase done");
		// reset has to cut into a running erase, the only start taken then
		wr(A_CT, {23'h0, wp, 8'h03});
		repeat (100) @(posedge sys_clk);
		op(3'h7);
		sbyte("reset op", 8'hE0, 1'b0);
		$display("test device reset done");
		complete_run;
	end
	initial
	begin
		#500000;
		n_errors++;
		complete_run;
	end
endmodule
